// ### bench/tcsrt_monitor.sv
// Port checker for tcsrt_top.
// Assumes it is bound to tcsrt_top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module tcsrt_monitor (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_en_in,
	input wire [7:0] sfr_wr_data_in,
	input wire sfr_rd_en_in,
	input wire [7:0] sfr_rd_data_out,
	input wire timer0_counter_mode_in,
	input wire timer1_counter_mode_in,
	input wire t2_interrupt_enable_in,
	input wire timer0_tick_out,
	input wire timer1_tick_out,
	input wire t2_irq_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
////////////////////////////////////////////////////////////////
// Shadows of software-written control bits
reg [7:0] ck_r;
reg [7:0] t2c_r;
wire wr_t2c = sfr_wr_en_in && sfr_addr_in == 8'hC8;
always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		ck_r <= 8'h00;
		t2c_r <= 8'h00;
	end else begin
		if (sfr_wr_en_in && sfr_addr_in == 8'h8E)
			ck_r <= sfr_wr_data_in;
		if (wr_t2c)
			t2c_r <= sfr_wr_data_in;
	end
end
////////////////////////////////////////////////////////////////
sequence s_rd_ck;
	sfr_rd_en_in && sfr_addr_in == 8'h8E;
endsequence
property p_rsv_zero;
	s_rd_ck |=> sfr_rd_data_out[7:6] == 2'h0;
endproperty
a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");
property p_unmapped;
	sfr_rd_en_in && sfr_addr_in == 8'h00 |=> sfr_rd_data_out == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
property p_t1_ext;
	timer1_counter_mode_in |-> !timer1_tick_out;
endproperty
a_t1_ext: assert property (p_t1_ext) else $error("timer1 tick in counter mode");
property p_t0_ext;
	timer0_counter_mode_in |-> !timer0_tick_out;
endproperty
a_t0_ext: assert property (p_t0_ext) else $error("timer0 tick in counter mode");
property p_t0_sys;
	ck_r[2] && !timer0_counter_mode_in |-> timer0_tick_out;
endproperty
a_t0_sys: assert property (p_t0_sys) else $error("timer0 not on system clock");
property p_irq_en;
	!t2_interrupt_enable_in |-> !t2_irq_out;
endproperty
a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
property p_flag_hold;
	t2_irq_out && !wr_t2c |=> t2_irq_out || !t2_interrupt_enable_in;
endproperty
a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
sequence s_irq_new;
	$rose(t2_irq_out) && $stable(t2_interrupt_enable_in) && !$past(wr_t2c);
endsequence
property p_stopped;
	s_irq_new |-> $past(t2c_r[2]) || $past(t2c_r[3]);
endproperty
a_stopped: assert property (p_stopped) else $error("overflow while stopped");
endmodule
`default_nettype wire

// ### bench/tcsrt_top_tb.sv
// Self-checking bench for tcsrt_top through its register port.
// Assumes the design files and tcsrt_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tcsrt_top_tb;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [7:0] addr = 8'h00;
reg [7:0] wd = 8'h00;
reg wen = 1'b0;
reg ren = 1'b0;
reg ext = 1'b0;
reg m0 = 1'b0;
reg m1 = 1'b0;
reg ien = 1'b1;
wire [7:0] rdat;
wire tk0;
wire tk1;
wire irq;
integer error_cnt = 0;
integer n_compared = 0;
integer c0;
integer c1;
integer i;
integer e;
initial begin
	forever #2 clk = ~clk;
end
tcsrt_top u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr),
	.sfr_wr_en_in(wen), .sfr_wr_data_in(wd), .sfr_rd_en_in(ren), .sfr_rd_data_out(rdat),
	.ext_osc_in(ext), .timer0_counter_mode_in(m0), .timer1_counter_mode_in(m1),
	.t2_interrupt_enable_in(ien), .timer0_tick_out(tk0), .timer1_tick_out(tk1),
	.t2_irq_out(irq));
////////////////////////////////////////////////////////////////
task chk(input [7:0] got, input [7:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	end
endtask
task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge clk);
		addr = a;
		wd = d;
		wen = 1'b1;
		@(negedge clk);
		wen = 1'b0;
	end
endtask
task rdc(input [7:0] a, input [7:0] x);
	begin
		@(negedge clk);
		addr = a;
		ren = 1'b1;
		@(negedge clk);
		ren = 1'b0;
		chk(rdat, x);
	end
endtask
// Timer 2 run bit is held set for exactly two clock edges
task run2(input [7:0] d);
	begin
		wr(8'hC8, d);
		wr(8'hC8, d & 8'hFB);
	end
endtask
task cnt(input integer n);
	begin
		c0 = 0;
		c1 = 0;
		repeat (n) begin
			@(negedge clk);
			c0 = c0 + tk0;
			c1 = c1 + tk1;
		end
	end
endtask
task extp(input integer n);
	begin
		repeat (n) begin
			repeat (3) @(negedge clk);
			ext = 1'b1;
			repeat (3) @(negedge clk);
			ext = 1'b0;
		end
		repeat (6) @(negedge clk);
	end
endtask
task test_done;
	begin
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
endtask
initial begin
	#100000;
	error_cnt = error_cnt + 1;
	test_done;
end
////////////////////////////////////////////////////////////////
initial begin
	repeat (16) @(negedge clk);
	rst_n = 1'b1;
	rdc(8'h8E, 8'h00);
	rdc(8'h00, 8'h00);
	wr(8'h8E, 8'h3F);
	rdc(8'h8E, 8'h3F);
	m1 = 1'b1;
	cnt(96);
	chk(c0[7:0], 8'd96);
	chk(c1[7:0], 8'h00);
	m1 = 1'b0;
	for (i = 0; i < 3; i = i + 1) begin
		wr(8'h8E, i[7:0]);
		cnt(96);
		e = (i == 0) ? 8 : (i == 1) ? 24 : 2;
		chk(c0[7:0], e[7:0]);
		chk(c1[7:0], e[7:0]);
	end
	wr(8'h8E, 8'h03);
	fork
		extp(16);
		cnt(110);
	join
	chk(c0[7:0], 8'h02);
	wr(8'h8E, 8'h10);
	wr(8'hCA, 8'h34);
	wr(8'hCB, 8'h12);
	wr(8'hCC, 8'hFE);
	wr(8'hCD, 8'h00);
	run2(8'h04);
	rdc(8'hCC, 8'h00);
	rdc(8'hCD, 8'h01);
	rdc(8'hC8, 8'h40);
	chk({7'h00, irq}, 8'h00);
	wr(8'hC8, 8'h60);
	chk({7'h00, irq}, 8'h01);
	wr(8'hC8, 8'h00);
	wr(8'hCC, 8'hFE);
	wr(8'hCD, 8'hFF);
	run2(8'h04);
	rdc(8'hCC, 8'h34);
	rdc(8'hCD, 8'h12);
	repeat (20) @(negedge clk);
	rdc(8'hC8, 8'hC0);
	chk({7'h00, irq}, 8'h01);
	ien = 1'b0;
	@(negedge clk);
	chk({7'h00, irq}, 8'h00);
	ien = 1'b1;
	wr(8'hC8, 8'h00);
	chk({7'h00, irq}, 8'h00);
	m0 = 1'b1;
	wr(8'h8E, 8'h20);
	run2(8'h05);
	rdc(8'hCD, 8'h12);
	wr(8'hCA, 8'h80);
	wr(8'hCB, 8'h50);
	wr(8'hCC, 8'hFF);
	wr(8'hCD, 8'hFE);
	run2(8'h0D);
	rdc(8'hCD, 8'h50);
	rdc(8'hC8, 8'h89);
	chk({7'h00, irq}, 8'h01);
	extp(8);
	rdc(8'hCC, 8'h80);
	rdc(8'hC8, 8'hC9);
	wr(8'hC8, 8'h49);
	chk({7'h00, irq}, 8'h00);
	wr(8'hC8, 8'h69);
	chk({7'h00, irq}, 8'h01);
	test_done;
end
endmodule
bind tcsrt_top tcsrt_monitor u_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_en_in(sfr_wr_en_in), .sfr_wr_data_in(sfr_wr_data_in),
	.sfr_rd_en_in(sfr_rd_en_in), .sfr_rd_data_out(sfr_rd_data_out),
	.timer0_counter_mode_in(timer0_counter_mode_in),
	.timer1_counter_mode_in(timer1_counter_mode_in),
	.t2_interrupt_enable_in(t2_interrupt_enable_in), .timer0_tick_out(timer0_tick_out),
	.timer1_tick_out(timer1_tick_out), .t2_irq_out(t2_irq_out));
`default_nettype wire

// ### hw/tcsrt_consts.vh
// Constants for the timer clock select and reload timer block.
// Assumes an 8-bit special-function register port with 8-bit addresses.
`ifndef TCSRT_CONSTS_VH
`define TCSRT_CONSTS_VH

// Register addresses
`define TCSRT_CLK_CTRL_ADDR 8'h8E
`define TCSRT_T2_CTRL_ADDR 8'hC8
`define TCSRT_T2_RELOAD_LOW_ADDR 8'hCA
`define TCSRT_T2_RELOAD_HIGH_ADDR 8'hCB
`define TCSRT_T2_COUNT_LOW_ADDR 8'hCC
`define TCSRT_T2_COUNT_HIGH_ADDR 8'hCD

// Reset values
`define TCSRT_CLK_CTRL_RESET 6'h00
`define TCSRT_T2_CTRL_RESET 8'h00
`define TCSRT_BYTE_RESET 8'h00
`define TCSRT_BYTE_MAX 8'hFF

// Clock control fields
`define TCSRT_CK_T2_HIGH_SEL 5
`define TCSRT_CK_T2_LOW_SEL 4
`define TCSRT_CK_T1_SEL 3
`define TCSRT_CK_T0_SEL 2
`define TCSRT_CK_PRESCALE_HI 1
`define TCSRT_CK_PRESCALE_LO 0

// Prescale field codes
`define TCSRT_PRESCALE_DIV12 2'h0
`define TCSRT_PRESCALE_DIV4 2'h1
`define TCSRT_PRESCALE_DIV48 2'h2
`define TCSRT_PRESCALE_EXT8 2'h3

// Timer 2 control fields
`define TCSRT_T2_HIGH_FLAG 7
`define TCSRT_T2_LOW_FLAG 6
`define TCSRT_T2_LOW_IRQ_EN 5
`define TCSRT_T2_CAPTURE_EN 4
`define TCSRT_T2_SPLIT 3
`define TCSRT_T2_RUN 2
`define TCSRT_T2_EXT_SEL 0

// Divide ratios, in counted source edges
`define TCSRT_DIV_SYS12 12
`define TCSRT_DIV_SYS4 4
`define TCSRT_DIV_SYS48 48
`define TCSRT_DIV_EXT8 8

`endif

// ### hw/tcsrt_div.v
// Divider: one-cycle pulse every DIV enable pulses.
// Assumes en_in is synchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module tcsrt_div #(
	parameter DIV = 12,
	parameter W = 6
) (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire en_in,
	output reg tick_out
);
	localparam integer LAST_I = DIV - 1;
	localparam [W-1:0] LAST = LAST_I[W-1:0];
	reg [W-1:0] cnt_r;

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= {W{1'b0}};
			tick_out <= 1'b0;
		end else begin
			tick_out <= en_in && (cnt_r == LAST);
			if (en_in) begin
				if (cnt_r == LAST) begin
					cnt_r <= {W{1'b0}};
				end else begin
					cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/tcsrt_sync.v
// Two-flop synchroniser with a rising-edge pulse.
// Assumes the input is asynchronous to core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module tcsrt_sync (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire async_in,
	output reg rise_out
);
	reg meta_r;
	reg sync_r;
	reg prev_r;

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise_out <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
			rise_out <= sync_r & ~prev_r;
		end
	end
endmodule
`default_nettype wire

// ### hw/tcsrt_top.v
// Timer clock selection and timer 2 auto-reload timer.
// Assumes a synchronous 8-bit register port and one system clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcsrt_consts.vh"
module tcsrt_top #(
	parameter DIV_SYS12 = `TCSRT_DIV_SYS12,
	parameter DIV_SYS4 = `TCSRT_DIV_SYS4,
	parameter DIV_SYS48 = `TCSRT_DIV_SYS48,
	parameter DIV_EXT8 = `TCSRT_DIV_EXT8
) (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_en_in,
	input wire [7:0] sfr_wr_data_in,
	input wire sfr_rd_en_in,
	output reg [7:0] sfr_rd_data_out,
	input wire ext_osc_in,
	input wire timer0_counter_mode_in,
	input wire timer1_counter_mode_in,
	input wire t2_interrupt_enable_in,
	output wire timer0_tick_out,
	output wire timer1_tick_out,
	output wire t2_irq_out
);

////////////////////////////////////////////////////////////////////////////////
// Register state

	reg [5:0] timer_clock_control_r;
	reg t2_high_overflow_flag_r;
	reg t2_low_overflow_flag_r;
	reg t2_low_interrupt_enable_r;
	reg t2_capture_enable_r;
	reg t2_split_mode_r;
	reg t2_run_r;
	reg t2_external_clock_select_r;
	reg [7:0] t2_count_low_r;
	reg [7:0] t2_count_high_r;
	reg [7:0] t2_reload_low_r;
	reg [7:0] t2_reload_high_r;

	reg [7:0] t2_count_low_nxt;
	reg [7:0] t2_count_high_nxt;
	reg t2_high_overflow_flag_nxt;
	reg t2_low_overflow_flag_nxt;
	reg [7:0] rd_data_nxt;

	wire wr_clk_ctrl;
	wire wr_t2_ctrl;
	wire wr_reload_low;
	wire wr_reload_high;
	wire wr_count_low;
	wire wr_count_high;

	assign wr_clk_ctrl = sfr_wr_en_in && (sfr_addr_in == `TCSRT_CLK_CTRL_ADDR);
	assign wr_t2_ctrl = sfr_wr_en_in && (sfr_addr_in == `TCSRT_T2_CTRL_ADDR);
	assign wr_reload_low = sfr_wr_en_in && (sfr_addr_in == `TCSRT_T2_RELOAD_LOW_ADDR);
	assign wr_reload_high = sfr_wr_en_in && (sfr_addr_in == `TCSRT_T2_RELOAD_HIGH_ADDR);
	assign wr_count_low = sfr_wr_en_in && (sfr_addr_in == `TCSRT_T2_COUNT_LOW_ADDR);
	assign wr_count_high = sfr_wr_en_in && (sfr_addr_in == `TCSRT_T2_COUNT_HIGH_ADDR);

	wire t2_high_byte_clock_select;
	wire t2_low_byte_clock_select;
	wire timer1_clock_select;
	wire timer0_clock_select;
	wire [1:0] prescale_sel;

	assign t2_high_byte_clock_select = timer_clock_control_r[`TCSRT_CK_T2_HIGH_SEL];
	assign t2_low_byte_clock_select = timer_clock_control_r[`TCSRT_CK_T2_LOW_SEL];
	assign timer1_clock_select = timer_clock_control_r[`TCSRT_CK_T1_SEL];
	assign timer0_clock_select = timer_clock_control_r[`TCSRT_CK_T0_SEL];
	assign prescale_sel = {timer_clock_control_r[`TCSRT_CK_PRESCALE_HI],
		timer_clock_control_r[`TCSRT_CK_PRESCALE_LO]};

////////////////////////////////////////////////////////////////////////////////
// Clock sources

	wire ext_rise;
	wire tick_ext8;
	wire tick_sys12;
	wire tick_sys4;
	wire tick_sys48;

	// Wide enough for any divide ratio below 4096
	localparam DIV_W = 12;

	tcsrt_sync u_ext_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(ext_osc_in),
		.rise_out(ext_rise)
	);

	tcsrt_div #(.DIV(DIV_EXT8), .W(DIV_W)) u_div_ext8 (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.en_in(ext_rise),
		.tick_out(tick_ext8)
	);

	tcsrt_div #(.DIV(DIV_SYS12), .W(DIV_W)) u_div_sys12 (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.en_in(1'b1),
		.tick_out(tick_sys12)
	);

	tcsrt_div #(.DIV(DIV_SYS4), .W(DIV_W)) u_div_sys4 (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.en_in(1'b1),
		.tick_out(tick_sys4)
	);

	tcsrt_div #(.DIV(DIV_SYS48), .W(DIV_W)) u_div_sys48 (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.en_in(1'b1),
		.tick_out(tick_sys48)
	);

////////////////////////////////////////////////////////////////////////////////
// Timer 0 and timer 1 count enables

	reg tick_prescaled;

	always @* begin
		case (prescale_sel)
			`TCSRT_PRESCALE_DIV12: tick_prescaled = tick_sys12;
			`TCSRT_PRESCALE_DIV4: tick_prescaled = tick_sys4;
			`TCSRT_PRESCALE_DIV48: tick_prescaled = tick_sys48;
			`TCSRT_PRESCALE_EXT8: tick_prescaled = tick_ext8;
			default: tick_prescaled = 1'b0;
		endcase
	end

	// Counter mode takes its events elsewhere, so no tick is offered
	assign timer0_tick_out = ~timer0_counter_mode_in &
		(timer0_clock_select | tick_prescaled);
	assign timer1_tick_out = ~timer1_counter_mode_in &
		(timer1_clock_select | tick_prescaled);

////////////////////////////////////////////////////////////////////////////////
// Timer 2 byte clocks

	wire tick_t2_sel;
	wire tick_low;
	wire tick_high;

	assign tick_t2_sel = t2_external_clock_select_r ? tick_ext8 : tick_sys12;
	assign tick_low = t2_low_byte_clock_select | tick_t2_sel;
	assign tick_high = t2_high_byte_clock_select | tick_t2_sel;

////////////////////////////////////////////////////////////////////////////////
// Timer 2 counting

	wire low_en;
	wire low_wrap;
	wire high_en;
	wire high_wrap;

	assign low_en = t2_split_mode_r ? tick_low : (t2_run_r & tick_low);
	assign low_wrap = low_en && (t2_count_low_r == `TCSRT_BYTE_MAX);
	assign high_en = t2_split_mode_r ? (t2_run_r & tick_high) : low_wrap;
	assign high_wrap = high_en && (t2_count_high_r == `TCSRT_BYTE_MAX);

	always @* begin
		t2_count_low_nxt = t2_count_low_r;
		t2_count_high_nxt = t2_count_high_r;
		if (t2_split_mode_r) begin
			if (low_wrap) begin
				t2_count_low_nxt = t2_reload_low_r;
			end else if (low_en) begin
				t2_count_low_nxt = t2_count_low_r + 8'h01;
			end
		end else begin
			if (high_wrap) begin
				t2_count_low_nxt = t2_reload_low_r;
			end else if (low_en) begin
				t2_count_low_nxt = t2_count_low_r + 8'h01;
			end
		end
		if (high_wrap) begin
			t2_count_high_nxt = t2_reload_high_r;
		end else if (high_en) begin
			t2_count_high_nxt = t2_count_high_r + 8'h01;
		end
		if (wr_count_low) begin
			t2_count_low_nxt = sfr_wr_data_in;
		end
		if (wr_count_high) begin
			t2_count_high_nxt = sfr_wr_data_in;
		end
	end

	// Hardware sets win over a software write in the same cycle
	always @* begin
		t2_high_overflow_flag_nxt = t2_high_overflow_flag_r;
		t2_low_overflow_flag_nxt = t2_low_overflow_flag_r;
		if (wr_t2_ctrl) begin
			t2_high_overflow_flag_nxt = sfr_wr_data_in[`TCSRT_T2_HIGH_FLAG];
			t2_low_overflow_flag_nxt = sfr_wr_data_in[`TCSRT_T2_LOW_FLAG];
		end
		if (high_wrap) begin
			t2_high_overflow_flag_nxt = 1'b1;
		end
		if (low_wrap) begin
			t2_low_overflow_flag_nxt = 1'b1;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Register updates

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_clock_control_r <= `TCSRT_CLK_CTRL_RESET;
			t2_high_overflow_flag_r <= 1'b0;
			t2_low_overflow_flag_r <= 1'b0;
			t2_low_interrupt_enable_r <= 1'b0;
			t2_capture_enable_r <= 1'b0;
			t2_split_mode_r <= 1'b0;
			t2_run_r <= 1'b0;
			t2_external_clock_select_r <= 1'b0;
			t2_count_low_r <= `TCSRT_BYTE_RESET;
			t2_count_high_r <= `TCSRT_BYTE_RESET;
			t2_reload_low_r <= `TCSRT_BYTE_RESET;
			t2_reload_high_r <= `TCSRT_BYTE_RESET;
		end else begin
			if (wr_clk_ctrl) begin
				timer_clock_control_r <= sfr_wr_data_in[5:0];
			end
			if (wr_t2_ctrl) begin
				t2_low_interrupt_enable_r <= sfr_wr_data_in[`TCSRT_T2_LOW_IRQ_EN];
				t2_capture_enable_r <= sfr_wr_data_in[`TCSRT_T2_CAPTURE_EN];
				t2_split_mode_r <= sfr_wr_data_in[`TCSRT_T2_SPLIT];
				t2_run_r <= sfr_wr_data_in[`TCSRT_T2_RUN];
				t2_external_clock_select_r <= sfr_wr_data_in[`TCSRT_T2_EXT_SEL];
			end
			t2_high_overflow_flag_r <= t2_high_overflow_flag_nxt;
			t2_low_overflow_flag_r <= t2_low_overflow_flag_nxt;
			if (wr_reload_low) begin
				t2_reload_low_r <= sfr_wr_data_in;
			end
			if (wr_reload_high) begin
				t2_reload_high_r <= sfr_wr_data_in;
			end
			t2_count_low_r <= t2_count_low_nxt;
			t2_count_high_r <= t2_count_high_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Interrupt request

	wire high_irq_src;
	wire low_irq_src;

	assign high_irq_src = t2_high_overflow_flag_r;
	assign low_irq_src = t2_low_interrupt_enable_r & t2_low_overflow_flag_r;
	assign t2_irq_out = t2_interrupt_enable_in & (high_irq_src | low_irq_src);

////////////////////////////////////////////////////////////////////////////////
// Read port

	wire [7:0] t2_control_rd;

	// Bit 1 of the control word is not implemented and reads zero
	assign t2_control_rd = {t2_high_overflow_flag_r, t2_low_overflow_flag_r,
		t2_low_interrupt_enable_r, t2_capture_enable_r, t2_split_mode_r, t2_run_r,
		1'b0, t2_external_clock_select_r};

	always @* begin
		case (sfr_addr_in)
			`TCSRT_CLK_CTRL_ADDR: rd_data_nxt = {2'h0, timer_clock_control_r};
			`TCSRT_T2_CTRL_ADDR: rd_data_nxt = t2_control_rd;
			`TCSRT_T2_RELOAD_LOW_ADDR: rd_data_nxt = t2_reload_low_r;
			`TCSRT_T2_RELOAD_HIGH_ADDR: rd_data_nxt = t2_reload_high_r;
			`TCSRT_T2_COUNT_LOW_ADDR: rd_data_nxt = t2_count_low_r;
			`TCSRT_T2_COUNT_HIGH_ADDR: rd_data_nxt = t2_count_high_r;
			default: rd_data_nxt = 8'h00;
		endcase
	end

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sfr_rd_data_out <= 8'h00;
		end else if (sfr_rd_en_in) begin
			sfr_rd_data_out <= rd_data_nxt;
		end
	end

endmodule
`default_nettype wire
